// file: hdl/gdac_pkg.sv
package gdac_pkg;

    // clock and timing
    localparam int unsigned CLK_PERIOD_PS   = 4000;
    localparam int unsigned DEAD_TIME_NS    = 50;
    localparam int unsigned DEAD_CYCLES     = (DEAD_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned GATE_RESET_NS   = 100;
    localparam int unsigned RESET_CYCLES    = (GATE_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned OC_OFFTIME_NS   = 1000;
    localparam int unsigned OFFTIME_CYCLES  = (OC_OFFTIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned CNT_W           = 8;

    // command word layout
    localparam int unsigned WORD_W          = 16;
    localparam int unsigned DATA_W          = 11;
    localparam int unsigned READ_BIT        = 15;
    localparam int unsigned ADDR_HI         = 14;
    localparam int unsigned ADDR_LO         = 11;

    // register addresses
    localparam logic [3:0] ADDR_STATUS1     = 4'h0;
    localparam logic [3:0] ADDR_STATUS2     = 4'h1;
    localparam logic [3:0] ADDR_GATE_CTRL   = 4'h2;
    localparam logic [3:0] ADDR_AMP_CTRL    = 4'h3;

    // reset values and masks
    localparam logic [10:0] GATE_CTRL_RST   = 11'h000;
    localparam logic [10:0] AMP_CTRL_RST    = 11'h000;
    localparam logic [10:0] AMP_CTRL_MASK   = 11'h07f;
    localparam logic [10:0] DATA_ZERO       = 11'h000;

    // gate_driver_control fields
    localparam int unsigned GC_CUR_LO       = 0;
    localparam int unsigned GC_RESET_BIT    = 2;
    localparam int unsigned GC_THREE_BIT    = 3;
    localparam int unsigned GC_OCR_LO       = 4;
    localparam int unsigned GC_THR_LO       = 6;

    // amp_and_misc_control fields
    localparam int unsigned AC_WARN_LO      = 0;
    localparam int unsigned AC_GAIN_LO      = 2;
    localparam int unsigned AC_SHORT1_BIT   = 4;
    localparam int unsigned AC_SHORT2_BIT   = 5;
    localparam int unsigned AC_OFFTIME_BIT  = 6;

    // status word 1 fields
    localparam int unsigned ST_SHUTDOWN_BIT = 10;
    localparam int unsigned ST_OT_SHUT_BIT  = 7;
    localparam int unsigned ST_OT_WARN_BIT  = 6;

    // overcurrent response codes
    localparam logic [1:0] OCR_LIMIT        = 2'h0;
    localparam logic [1:0] OCR_LATCH        = 2'h1;
    localparam logic [1:0] OCR_REPORT       = 2'h2;
    localparam logic [1:0] OCR_OFF          = 2'h3;

    // warning pin source codes
    localparam logic [1:0] WARN_BOTH        = 2'h0;
    localparam logic [1:0] WARN_OT          = 2'h1;

    // drain-source trip thresholds in millivolts
    localparam int unsigned MV_W            = 12;
    localparam logic [11:0] VDS_TRIP_MV [32] = '{
        12'h03c, 12'h044, 12'h04c, 12'h056, 12'h061, 12'h06d, 12'h07b, 12'h08a,
        12'h09b, 12'h0af, 12'h0c5, 12'h0de, 12'h0fa, 12'h11a, 12'h13d, 12'h166,
        12'h193, 12'h1c6, 12'h1ff, 12'h240, 12'h288, 12'h2da, 12'h336, 12'h39e,
        12'h413, 12'h497, 12'h52c, 12'h5d3, 12'h68f, 12'h764, 12'h853, 12'h960};

    typedef enum logic {GDAC_GR_IDLE, GDAC_GR_BUSY} gdac_gr_e;

endpackage : gdac_pkg

// file: hdl/gdac_vds_table.sv
`timescale 1ns/100ps
`default_nettype none
module gdac_vds_table
    import gdac_pkg::*;
(
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic [4:0]   code,
    output logic [MV_W-1:0]   thr_mv
);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            thr_mv <= VDS_TRIP_MV[0];
        end else begin
            thr_mv <= VDS_TRIP_MV[code];
        end
    end

endmodule : gdac_vds_table
`default_nettype wire

// file: hdl/gdac_phase.sv
`timescale 1ns/100ps
`default_nettype none
module gdac_phase
    import gdac_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic hi_req,
    input  wire logic lo_req,
    input  wire logic three_input,
    input  wire logic trip_limit,
    input  wire logic offtime_en,
    input  wire logic force_off,
    output logic      gate_hi,
    output logic      gate_lo
);

    logic             hi_req_d_reg;
    logic             want_h_d_reg;
    logic             block_reg;
    logic [CNT_W-1:0] off_cnt_reg;
    logic [CNT_W-1:0] dead_cnt_reg;
    logic             want_h;
    logic             want_l;
    logic             change;
    logic             unblock;

    assign want_h  = hi_req;
    assign want_l  = three_input ? !hi_req : lo_req;
    assign change  = three_input && (want_h != want_h_d_reg);
    assign unblock = offtime_en ? (off_cnt_reg == CNT_W'(1))
                                : (hi_req && !hi_req_d_reg);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hi_req_d_reg <= 1'b0;
            want_h_d_reg <= 1'b0;
        end else begin
            hi_req_d_reg <= hi_req;
            want_h_d_reg <= want_h;
        end
    end

    // current limiting: phase held off until next pwm cycle or off time ends
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            block_reg   <= 1'b0;
            off_cnt_reg <= '0;
        end else begin
            if (trip_limit) begin
                block_reg   <= 1'b1;
                off_cnt_reg <= CNT_W'(OFFTIME_CYCLES);
            end else begin
                if (unblock) begin
                    block_reg <= 1'b0;
                end
                if (off_cnt_reg != '0) begin
                    off_cnt_reg <= off_cnt_reg - CNT_W'(1);
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dead_cnt_reg <= '0;
        end else if (change) begin
            dead_cnt_reg <= CNT_W'(DEAD_CYCLES);
        end else if (dead_cnt_reg != '0) begin
            dead_cnt_reg <= dead_cnt_reg - CNT_W'(1);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gate_hi <= 1'b0;
            gate_lo <= 1'b0;
        end else begin
            gate_hi <= want_h && !block_reg && !force_off && !trip_limit && !change && (dead_cnt_reg == '0);
            gate_lo <= want_l && !block_reg && !force_off && !trip_limit && !change && (dead_cnt_reg == '0);
        end
    end

    three_no_overlap_a: assert property (@(posedge mclk) disable iff (!rst_n)
        three_input |=> !(gate_hi && gate_lo))
        else $error("both gates of a phase on in three input mode");

    six_independent_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!three_input && lo_req && !block_reg && !force_off && !trip_limit && dead_cnt_reg == '0) |=> gate_lo)
        else $error("low gate did not follow its own input");

endmodule : gdac_phase
`default_nettype wire

// file: hdl/gdac_regs.sv
`timescale 1ns/100ps
`default_nettype none
module gdac_regs
    import gdac_pkg::*;
#(
    parameter logic [3:0] DEVICE_ID = 4'h5   // arbitrary value
)
(
    input  wire logic            mclk,
    input  wire logic            rst_n,
    input  wire logic            cmd_valid,
    input  wire logic [15:0]     cmd_word,
    input  wire logic [2:0]      pwm_hi_in,
    input  wire logic [2:0]      pwm_lo_in,
    input  wire logic            ot_warn_in,
    input  wire logic            ot_shutdown_in,
    input  wire logic [6*12-1:0] vds_mv,
    output logic [15:0]          resp_word,
    output logic [2:0]           gate_hi,
    output logic [2:0]           gate_lo,
    output logic [1:0]           gate_current_sel,
    output logic [1:0]           amp_gain_sel,
    output logic                 amp1_input_short,
    output logic                 amp2_input_short,
    output logic                 fault_n,
    output logic                 warning_pin_n
);

    localparam int GR_MAX = 27;

    logic [10:0]      gate_ctrl_reg;
    logic [10:0]      amp_ctrl_reg;
    logic [10:0]      status1_reg;
    logic             shutdown_reg;
    gdac_gr_e         gr_state_reg;
    logic [CNT_W-1:0] gr_cnt_reg;
    logic [2:0]       hi_meta_reg, hi_sync_reg;
    logic [2:0]       lo_meta_reg, lo_sync_reg;
    logic [1:0]       ot_meta_reg, ot_sync_reg;
    logic [MV_W-1:0]  thr_mv;
    logic [5:0]       gate_on;
    logic [5:0]       trip;
    logic [2:0]       trip_limit;
    logic             force_off;
    logic             wr_en;
    logic             rd_en;
    logic [3:0]       cmd_addr;
    logic [10:0]      cmd_data;
    logic [1:0]       ocr;
    logic [1:0]       warn_src;
    logic             status_clr;
    logic [10:0]      status_set;
    logic             warn;
    logic [10:0]      rd_data;

    assign cmd_addr = cmd_word[ADDR_HI:ADDR_LO];
    assign cmd_data = cmd_word[DATA_W-1:0];
    assign wr_en    = cmd_valid && !cmd_word[READ_BIT];
    assign rd_en    = cmd_valid && cmd_word[READ_BIT];
    assign ocr      = gate_ctrl_reg[GC_OCR_LO +: 2];
    assign warn_src = amp_ctrl_reg[AC_WARN_LO +: 2];
    assign force_off = shutdown_reg || (gr_state_reg == GDAC_GR_BUSY);

    // pin synchronisers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hi_meta_reg <= '0;
            hi_sync_reg <= '0;
            lo_meta_reg <= '0;
            lo_sync_reg <= '0;
            ot_meta_reg <= '0;
            ot_sync_reg <= '0;
        end else begin
            hi_meta_reg <= pwm_hi_in;
            hi_sync_reg <= hi_meta_reg;
            lo_meta_reg <= pwm_lo_in;
            lo_sync_reg <= lo_meta_reg;
            ot_meta_reg <= {ot_shutdown_in, ot_warn_in};
            ot_sync_reg <= ot_meta_reg;
        end
    end

    // gate_driver_control register and its self-clearing reset bit
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gate_ctrl_reg <= GATE_CTRL_RST;
            gr_state_reg  <= GDAC_GR_IDLE;
            gr_cnt_reg    <= '0;
        end else begin
            if (wr_en && cmd_addr == ADDR_GATE_CTRL) begin
                gate_ctrl_reg <= cmd_data;
            end
            case (gr_state_reg)
                GDAC_GR_IDLE: begin
                    if (wr_en && cmd_addr == ADDR_GATE_CTRL && cmd_data[GC_RESET_BIT]) begin
                        gr_state_reg <= GDAC_GR_BUSY;
                        gr_cnt_reg   <= CNT_W'(RESET_CYCLES);
                    end
                end
                GDAC_GR_BUSY: begin
                    if (gr_cnt_reg == CNT_W'(1)) begin
                        gr_state_reg <= GDAC_GR_IDLE;
                        gate_ctrl_reg[GC_RESET_BIT] <= 1'b0;
                    end
                    if (gr_cnt_reg != '0) begin
                        gr_cnt_reg <= gr_cnt_reg - CNT_W'(1);
                    end
                end
                default: begin
                    gr_state_reg <= GDAC_GR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            amp_ctrl_reg <= AMP_CTRL_RST;
        end else if (wr_en && cmd_addr == ADDR_AMP_CTRL) begin
            amp_ctrl_reg <= cmd_data & AMP_CTRL_MASK;
        end
    end

    gdac_vds_table u_table (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .code   (gate_ctrl_reg[GC_THR_LO +: 5]),
        .thr_mv (thr_mv)
    );

    // per-phase detection and gate control
    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : g_phase
            assign gate_on[5-2*p] = gate_hi[p];
            assign gate_on[4-2*p] = gate_lo[p];
            assign trip[5-2*p] = (ocr != OCR_OFF) && gate_hi[p] && (vds_mv[(5-2*p)*MV_W +: MV_W] > thr_mv);
            assign trip[4-2*p] = (ocr != OCR_OFF) && gate_lo[p] && (vds_mv[(4-2*p)*MV_W +: MV_W] > thr_mv);
            assign trip_limit[p] = (ocr == OCR_LIMIT) && (trip[5-2*p] || trip[4-2*p]);

            gdac_phase u_phase (
                .mclk        (mclk),
                .rst_n       (rst_n),
                .hi_req      (hi_sync_reg[p]),
                .lo_req      (lo_sync_reg[p]),
                .three_input (gate_ctrl_reg[GC_THREE_BIT]),
                .trip_limit  (trip_limit[p]),
                .offtime_en  (amp_ctrl_reg[AC_OFFTIME_BIT]),
                .force_off   (force_off),
                .gate_hi     (gate_hi[p]),
                .gate_lo     (gate_lo[p])
            );
        end
    endgenerate

    // latched shutdown: overcurrent in latch mode or overtemperature shutdown
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shutdown_reg <= 1'b0;
        end else if ((ocr == OCR_LATCH && |trip) || ot_sync_reg[1]) begin
            shutdown_reg <= 1'b1;
        end else if (gr_state_reg == GDAC_GR_BUSY) begin
            shutdown_reg <= 1'b0;
        end
    end

    // status word 1, cleared on any command (read or write) or gate reset, set wins
    assign status_clr = cmd_valid || (gr_state_reg == GDAC_GR_BUSY);
    always_comb begin
        status_set = DATA_ZERO;
        status_set[5:0] = trip;
        status_set[ST_OT_WARN_BIT] = ot_sync_reg[0];
        status_set[ST_OT_SHUT_BIT] = ot_sync_reg[1];
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            status1_reg <= DATA_ZERO;
        end else begin
            status1_reg <= (status_clr ? DATA_ZERO : status1_reg) | status_set;
        end
    end

    always_comb begin
        rd_data = DATA_ZERO;
        case (cmd_addr)
            ADDR_STATUS1: begin
                rd_data = status1_reg;
                rd_data[ST_SHUTDOWN_BIT] = shutdown_reg;
            end
            ADDR_STATUS2:   rd_data = {7'h00, DEVICE_ID};
            ADDR_GATE_CTRL: rd_data = gate_ctrl_reg;
            ADDR_AMP_CTRL:  rd_data = amp_ctrl_reg;
            default:        rd_data = DATA_ZERO;
        endcase
        if (!cmd_word[READ_BIT]) begin
            rd_data = status1_reg;
            rd_data[ST_SHUTDOWN_BIT] = shutdown_reg;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            resp_word <= '0;
        end else if (rd_en) begin
            resp_word <= {1'b0, cmd_addr, rd_data};
        end else if (wr_en) begin
            resp_word <= {1'b0, ADDR_STATUS1, rd_data};
        end
    end

    // warning pin source
    always_comb begin
        case (warn_src)
            WARN_BOTH: warn = ot_sync_reg[0] || (|status1_reg[5:0]);
            WARN_OT:   warn = ot_sync_reg[0];
            default:   warn = |status1_reg[5:0];
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            warning_pin_n    <= 1'b1;
            fault_n          <= 1'b1;
            gate_current_sel <= '0;
            amp_gain_sel     <= '0;
            amp1_input_short <= 1'b0;
            amp2_input_short <= 1'b0;
        end else begin
            warning_pin_n    <= !warn;
            fault_n          <= !shutdown_reg;
            gate_current_sel <= gate_ctrl_reg[GC_CUR_LO +: 2];
            amp_gain_sel     <= amp_ctrl_reg[AC_GAIN_LO +: 2];
            amp1_input_short <= amp_ctrl_reg[AC_SHORT1_BIT];
            amp2_input_short <= amp_ctrl_reg[AC_SHORT2_BIT];
        end
    end

    gate_reset_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_en && cmd_addr == ADDR_GATE_CTRL && cmd_data[GC_RESET_BIT] && gr_state_reg == GDAC_GR_IDLE)
        |-> ##[1:GR_MAX] !gate_ctrl_reg[GC_RESET_BIT])
        else $error("gate reset bit did not clear itself");

    gate_reset_fault_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (gr_state_reg == GDAC_GR_BUSY && !ot_sync_reg[1] && !(ocr == OCR_LATCH && |trip)) |=> !shutdown_reg)
        else $error("shutdown not cleared by gate reset");

    fault_polarity_a: assert property (@(posedge mclk) disable iff (!rst_n)
        fault_n == !$past(shutdown_reg))
        else $error("fault pin not inverse of shutdown flag");

    latch_shutdown_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ocr == OCR_LATCH && |trip) |=> (shutdown_reg ##1 !fault_n))
        else $error("latch mode trip did not shut down");

    oc_disabled_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (ocr == OCR_OFF && status_clr) |=> (status1_reg[5:0] == 6'h00))
        else $error("trip seen while protection disabled");

    trip_cause_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (trip != 6'h00) |-> ((trip & ~gate_on) == 6'h00))
        else $error("trip raised for a transistor that is off");

    warn_ot_only_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (warn_src == WARN_OT && !ot_sync_reg[0]) |=> warning_pin_n)
        else $error("warning pin low without overtemperature");

    reserved_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
        amp_ctrl_reg[10:7] == 4'h0)
        else $error("reserved control bits not zero");

    gain_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_en && cmd_addr == ADDR_AMP_CTRL) |-> ##2 (amp_gain_sel == $past(cmd_data[3:2], 2)))
        else $error("gain select did not follow write");

endmodule : gdac_regs
`default_nettype wire

// file: bench/gdac_host.sv
`timescale 1ns/100ps
`default_nettype none
module gdac_host (
    input  wire logic   mclk,
    output logic        cmd_valid,
    output logic [15:0] cmd_word
);
    initial begin
        cmd_valid = 1'b0;
        cmd_word  = 16'h0000;
    end
    // idle word inverted so a stale word never looks valid
    task automatic xfer(input logic rd, input logic [3:0] a, input logic [10:0] d);
        @(negedge mclk);
        cmd_word  = {rd, a, d};
        cmd_valid = 1'b1;
        @(negedge mclk);
        cmd_valid = 1'b0;
        cmd_word  = ~cmd_word;
    endtask : xfer
endmodule : gdac_host
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    import gdac_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cmd_valid;
    logic [15:0] cmd_word;
    logic [2:0]  pwm_hi = 3'h0;
    logic [2:0]  pwm_lo = 3'h0;
    logic        ot_warn = 1'b0;
    logic        ot_shut = 1'b0;
    logic [71:0] vds = 72'h0;
    logic [15:0] resp_word;
    logic [2:0]  gate_hi;
    logic [2:0]  gate_lo;
    logic [1:0]  cur_sel;
    logic [1:0]  gain_sel;
    logic        short1;
    logic        short2;
    logic        fault_n;
    logic        warning_pin_n;
    logic [15:0] exp_q[$];
    logic [15:0] msk_q[$];
    logic [1:0]  pend = 2'h0;
    logic [1:0]  k;
    logic [10:0] v;
    int          n_fail = 0;
    int          cmp_count = 0;

    always #2 mclk = ~mclk;

    gdac_regs u_dut (.mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
        .pwm_hi_in(pwm_hi), .pwm_lo_in(pwm_lo), .ot_warn_in(ot_warn), .ot_shutdown_in(ot_shut),
        .vds_mv(vds), .resp_word(resp_word), .gate_hi(gate_hi), .gate_lo(gate_lo),
        .gate_current_sel(cur_sel), .amp_gain_sel(gain_sel), .amp1_input_short(short1),
        .amp2_input_short(short2), .fault_n(fault_n), .warning_pin_n(warning_pin_n));

    gdac_host u_host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_word(cmd_word));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // write answers carry status word 1, reads echo the address
    task automatic cmd(input logic rd, input logic [3:0] a, input logic [10:0] d,
                       input logic [10:0] e, input logic [10:0] m);
        exp_q.push_back(rd ? {1'b0, a, e} : {5'h00, e});
        msk_q.push_back({5'h1f, m});
        u_host.xfer(rd, a, d);
    endtask : cmd

    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask : idle

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    always @(posedge mclk) pend <= {pend[0], cmd_valid};

    always @(negedge mclk) begin
        if (pend[1]) begin
            check("resp_word", resp_word & msk_q[0], exp_q[0] & msk_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end

    initial begin
        #100000;
        n_fail++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'h73ae));
        idle(3);
        rst_n = 1'b1;
        check("fault_n", 16'(fault_n), 16'h1);
        check("warning_pin_n", 16'(warning_pin_n), 16'h1);
        cmd(1'b1, ADDR_GATE_CTRL, 11'h0, GATE_CTRL_RST, 11'h7ff);
        cmd(1'b1, ADDR_AMP_CTRL, 11'h0, AMP_CTRL_RST, 11'h7ff);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            v = {5'($urandom), 2'($urandom), 2'h0, 2'(i)};
            cmd(1'b0, ADDR_GATE_CTRL, v, DATA_ZERO, 11'h7ff);
            idle(3);
            check("gate_current_sel", 16'(cur_sel), 16'(i));
            cmd(1'b1, ADDR_GATE_CTRL, 11'h0, v, 11'h7ff);
        end
        for (int i = 0; i < 4; i++) begin
            k = 2'(i);
            v = {4'($urandom), 1'($urandom), k[1], k[0], k, 2'($urandom)};
            cmd(1'b0, ADDR_AMP_CTRL, v, DATA_ZERO, 11'h7ff);
            idle(3);
            check("amp_gain_sel", 16'(gain_sel), 16'(k));
            check("amp_shorts", 16'({short2, short1}), 16'(k));
            cmd(1'b1, ADDR_AMP_CTRL, 11'h0, v & AMP_CTRL_MASK, 11'h7ff);
        end
        $display("test registers done");
        cmd(1'b0, ADDR_GATE_CTRL, 11'h004, DATA_ZERO, 11'h7ff);
        idle(RESET_CYCLES + 15);
        cmd(1'b1, ADDR_GATE_CTRL, 11'h0, DATA_ZERO, 11'h7ff);
        repeat (4) begin
            pwm_hi = 3'($urandom);
            pwm_lo = 3'($urandom);
            idle(5);
            check("six_input", {gate_hi, gate_lo}, {pwm_hi, pwm_lo});
        end
        cmd(1'b0, ADDR_GATE_CTRL, 11'h008, DATA_ZERO, 11'h000);
        pwm_hi = 3'h0;
        idle(30);
        pwm_hi = 3'h5;
        idle(8);
        check("dead_time", 16'({gate_hi, gate_lo} & 6'h2d), 16'h0);
        idle(20);
        check("three_input", {gate_hi, gate_lo}, 16'h2a);
        $display("test gates done");
        cmd(1'b0, ADDR_AMP_CTRL, 11'h002, DATA_ZERO, 11'h000);
        cmd(1'b0, ADDR_GATE_CTRL, 11'h030, DATA_ZERO, 11'h000);
        pwm_hi = 3'h1;
        pwm_lo = 3'h0;
        vds = 72'h064 << 60;
        idle(10);
        check("warning_pin_n", 16'(warning_pin_n), 16'h1);
        cmd(1'b1, ADDR_STATUS1, 11'h0, DATA_ZERO, 11'h7ff);
        cmd(1'b0, ADDR_GATE_CTRL, 11'h020, DATA_ZERO, 11'h000);
        idle(10);
        check("warning_pin_n", 16'(warning_pin_n), 16'h0);
        check("fault_n", 16'(fault_n), 16'h1);
        cmd(1'b1, ADDR_STATUS1, 11'h0, 11'h020, 11'h7ff);
        cmd(1'b0, ADDR_GATE_CTRL, 11'h010, DATA_ZERO, 11'h000);
        idle(10);
        check("fault_n", 16'(fault_n), 16'h0);
        check("gate_hi", 16'(gate_hi), 16'h0);
        cmd(1'b1, ADDR_STATUS1, 11'h0, 11'h420, 11'h7ff);
        cmd(1'b0, ADDR_GATE_CTRL, 11'h034, DATA_ZERO, 11'h000);
        idle(RESET_CYCLES + 15);
        check("fault_n", 16'(fault_n), 16'h1);
        cmd(1'b1, ADDR_STATUS1, 11'h0, DATA_ZERO, 11'h7ff);
        $display("test overcurrent done");
        for (int t = 0; t < 2; t++) begin
            cmd(1'b0, ADDR_AMP_CTRL, {4'h0, 1'(t), 6'h02}, DATA_ZERO, 11'h000);
            vds = 72'h064 << 60;
            cmd(1'b0, ADDR_GATE_CTRL, 11'h000, DATA_ZERO, 11'h000);
            idle(10);
            check("limit_off", 16'(gate_hi[0]), 16'h0);
            vds = 72'h0;
            idle(OFFTIME_CYCLES + 10);
            check("recovery", 16'(gate_hi[0]), 16'(t));
            pwm_hi = 3'h0;
            idle(4);
            pwm_hi = 3'h1;
            idle(5);
            check("next_cycle", 16'(gate_hi[0]), 16'h1);
        end
        cmd(1'b0, ADDR_AMP_CTRL, 11'h001, DATA_ZERO, 11'h000);
        ot_warn = 1'b1;
        idle(6);
        check("warning_pin_n", 16'(warning_pin_n), 16'h0);
        ot_warn = 1'b0;
        idle(4);
        ot_shut = 1'b1;
        idle(6);
        check("fault_n", 16'(fault_n), 16'h0);
        cmd(1'b1, ADDR_STATUS1, 11'h0, 11'h480, 11'h480);
        ot_shut = 1'b0;
        idle(4);
        $display("test recovery done");
        end_of_test();
    end
endmodule : tb
`default_nettype wire
